//--- hw/qasc_channel.sv
// One asynchronous serial channel with a classic Wishbone register slave
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module qasc_channel
    import qasc_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic ser_rx_i,
    input wire logic cts_n_i,
    input wire logic dcd_n_i,
    input wire logic irq_mode_sel_i,
    output logic ser_tx_o,
    output logic rts_n_o,
    output logic dtr_n_o,
    output logic channel_irq_out_o,
    output logic channel_irq_oe_o
);
    localparam int AW = $clog2(DEPTH);

    logic [3:0] pin_raw, sync1, sync2, sync3, pin, agree;
    logic acc, wr, rd, dlab, loop, auto_on, cts, dcd, rx_in;
    logic wr_data, rd_data, wr_fifo, rd_iid, rd_lstat, rd_mstat;
    logic clr_rx, clr_tx, tick, tx_bit, tx_go, tx_push, tx_end;
    logic rx_push, rx_pop, ovr, rx_end, thre, temt, thre_q, thri;
    logic cts_q, dcd_q, dcts, ddcd, cts_chg, force_err;
    logic ls_int, rx_int, tx_int, ms_int, rx_full_lvl;
    logic [2:0] idx, last_bit, tidx, ridx;
    logic [7:0] d, line, scratch, mask, tx_head, tsh, rsh, rx_bits;
    logic [7:0] lstat, mstat, rdata;
    logic [15:0] divisor, bcnt;
    logic [3:0] ien, iid, lerr, lset;
    logic [5:0] mctl, stop_len, tsub, rsub;
    logic [1:0] trig;
    logic [4:0] lvl;
    logic fifo_en, tpar, rpar, rzero;
    logic [AW:0] cap, tcnt, rcnt;
    logic [AW-1:0] twp, trp, rwp, rrp;
    logic [7:0] txm [DEPTH];
    qasc_rx_entry_type rxm [DEPTH];
    qasc_rx_entry_type new_ent, rx_head;
    qasc_tx_state_type tx_st;
    qasc_rx_state_type rx_st;

    // Pins pass three flops; a change counts once stages 2 and 3 agree
    assign pin_raw = {irq_mode_sel_i, dcd_n_i, cts_n_i, ser_rx_i};
    assign agree = ~(sync2 ^ sync3);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= SYNC_RST;
            sync2 <= SYNC_RST;
            sync3 <= SYNC_RST;
            pin <= SYNC_RST;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            pin <= (sync3 & agree) | (pin & ~agree);
        end
    end

    // Bus decode; one access per cycle/strobe pair
    assign acc = cyc_i & stb_i & ~ack_o;
    assign idx = adr_i[4:2];
    assign d = dat_i[7:0];
    assign wr = acc & we_i & sel_i[0];
    assign rd = acc & ~we_i;
    assign dlab = line[LC_DLAB];
    assign wr_data = wr & (idx == REG_DATA) & ~dlab;
    assign rd_data = rd & (idx == REG_DATA) & ~dlab;
    assign wr_fifo = wr & (idx == REG_IID);
    assign rd_iid = rd & (idx == REG_IID);
    assign rd_lstat = rd & (idx == REG_LSTAT);
    assign rd_mstat = rd & (idx == REG_MSTAT);
    // Toggling FIFO mode flushes both queues to avoid stale entries
    assign clr_rx = wr_fifo & (d[1] | (d[0] != fifo_en));
    assign clr_tx = wr_fifo & (d[2] | (d[0] != fifo_en));

    // Software control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ien <= IEN_RST;
            line <= LINE_RST;
            mctl <= MCTL_RST;
            scratch <= 8'h00;
            divisor <= DIV_RST;
            fifo_en <= 1'b0;
            trig <= 2'h0;
        end else if (wr) begin
            case (idx)
                REG_DATA: if (dlab) divisor[7:0] <= d;
                REG_IEN: begin
                    if (dlab) divisor[15:8] <= d;
                    else ien <= d[3:0];
                end
                REG_IID: begin
                    fifo_en <= d[0];
                    trig <= d[7:6];
                end
                REG_LINE: line <= d;
                REG_MCTL: mctl <= d[5:0];
                REG_SCRATCH: scratch <= d;
                default: ;
            endcase
        end
    end

    // Sample tick at sixteen times the bit rate; divisor 0 halts it
    always_ff @(posedge clk_i) begin
        if (rst_i || divisor == 16'h0000) begin
            bcnt <= 16'h0000;
            tick <= 1'b0;
        end else if (bcnt >= divisor - 16'h0001) begin
            bcnt <= 16'h0000;
            tick <= 1'b1;
        end else begin
            bcnt <= bcnt + 16'h0001;
            tick <= 1'b0;
        end
    end

    // Loopback turns modem outputs back into the inputs
    assign loop = mctl[MC_LOOP];
    assign rx_in = loop ? (tx_bit & ~line[LC_BRK]) : pin[0];
    assign cts = loop ? mctl[MC_RTS] : ~pin[1];
    assign dcd = loop ? mctl[MC_GATE] : ~pin[2];
    assign auto_on = mctl[MC_AUTO] & fifo_en;

    // Frame shape from the line register
    assign last_bit = 3'h4 + {1'b0, line[1:0]};
    assign mask = 8'hff >> (3'h3 - {1'b0, line[1:0]});
    assign stop_len = ~line[LC_STOP] ? TICK_ONE :
        (line[1:0] == 2'h0 ? TICK_1P5 : TICK_TWO);
    // Depth one in non-FIFO mode gives the holding register
    assign cap = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);

    // Transmit queue; writes to a full queue are dropped
    assign tx_push = wr_data & (tcnt < cap);
    assign tx_go = (tx_st == TX_IDLE) & tick & (tcnt != '0) &
        (~auto_on | cts);
    assign tx_head = txm[trp] & mask;
    always_ff @(posedge clk_i) begin
        if (tx_push) txm[twp] <= d;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_tx) begin
            twp <= '0;
            trp <= '0;
            tcnt <= '0;
        end else begin
            if (tx_push) twp <= twp + AW'(1);
            if (tx_go) trp <= trp + AW'(1);
            tcnt <= tcnt + (AW+1)'(tx_push) - (AW+1)'(tx_go);
        end
    end

    // Transmit shifter, LSB first
    assign tx_end = tick & (tx_st == TX_STOP ? tsub == stop_len - 6'h01 :
        tsub == TICK_LAST);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_st <= TX_IDLE;
            tx_bit <= 1'b1;
            tsub <= 6'h00;
            tidx <= 3'h0;
            tsh <= 8'h00;
            tpar <= 1'b0;
        end else begin
            if (tick && tx_st != TX_IDLE)
                tsub <= tx_end ? 6'h00 : tsub + 6'h01;
            case (tx_st)
                TX_IDLE: if (tx_go) begin
                    tx_st <= TX_START;
                    tx_bit <= 1'b0;
                    tsub <= 6'h00;
                    tsh <= tx_head;
                    tpar <= ^tx_head ^ ~line[LC_EVEN];
                end
                TX_START: if (tx_end) begin
                    tx_st <= TX_DATA;
                    tx_bit <= tsh[0];
                    tsh <= tsh >> 1;
                    tidx <= 3'h0;
                end
                TX_DATA: if (tx_end) begin
                    if (tidx == last_bit) begin
                        tx_st <= line[LC_PEN] ? TX_PAR : TX_STOP;
                        tx_bit <= line[LC_PEN] ? tpar : 1'b1;
                    end else begin
                        tx_bit <= tsh[0];
                        tsh <= tsh >> 1;
                        tidx <= tidx + 3'h1;
                    end
                end
                TX_PAR: if (tx_end) begin
                    tx_st <= TX_STOP;
                    tx_bit <= 1'b1;
                end
                TX_STOP: if (tx_end) tx_st <= TX_IDLE;
                default: tx_st <= TX_IDLE;
            endcase
        end
    end

    // Receive framing; data lands in the top bits, shift it down
    assign rx_end = tick & (rsub == TICK_LAST);
    assign rx_bits = rsh >> (3'h3 - {1'b0, line[1:0]});
    assign new_ent.data = rx_bits;
    assign new_ent.pe = line[LC_PEN] &
        (^rx_bits ^ rpar ^ ~line[LC_EVEN]);
    assign new_ent.fe = ~rx_in;
    assign new_ent.brk = rzero & ~rx_in;
    assign rx_push = (rx_st == R_STOP) & rx_end & (rcnt < cap);
    assign ovr = (rx_st == R_STOP) & rx_end & (rcnt >= cap);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_st <= R_IDLE;
            rsub <= 6'h00;
            ridx <= 3'h0;
            rsh <= 8'h00;
            rpar <= 1'b0;
            rzero <= 1'b0;
        end else begin
            if (tick && rx_st != R_IDLE)
                rsub <= (rx_end || (rx_st == R_START && rsub == TICK_HALF))
                    ? 6'h00 : rsub + 6'h01;
            case (rx_st)
                R_IDLE: if (!rx_in) begin
                    rx_st <= R_START;
                    rsub <= 6'h00;
                end
                // Mid-bit recheck; a glitch falls back to idle
                R_START: if (tick && rsub == TICK_HALF) begin
                    rx_st <= rx_in ? R_IDLE : R_DATA;
                    ridx <= 3'h0;
                    rzero <= 1'b1;
                end
                R_DATA: if (rx_end) begin
                    rsh <= {rx_in, rsh[7:1]};
                    rzero <= rzero & ~rx_in;
                    ridx <= ridx + 3'h1;
                    if (ridx == last_bit)
                        rx_st <= line[LC_PEN] ? R_PAR : R_STOP;
                end
                R_PAR: if (rx_end) begin
                    rpar <= rx_in;
                    rzero <= rzero & ~rx_in;
                    rx_st <= R_STOP;
                end
                R_STOP: if (rx_end) rx_st <= rx_in ? R_IDLE : R_MARK;
                // After a break wait for mark before hunting a new start
                R_MARK: if (rx_in) rx_st <= R_IDLE;
                default: rx_st <= R_IDLE;
            endcase
        end
    end

    // Receive queue with error bits beside each byte
    assign rx_pop = rd_data & (rcnt != '0);
    assign rx_head = rxm[rrp];
    always_ff @(posedge clk_i) begin
        if (rx_push) rxm[rwp] <= new_ent;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_rx) begin
            rwp <= '0;
            rrp <= '0;
            rcnt <= '0;
        end else begin
            if (rx_push) rwp <= rwp + AW'(1);
            if (rx_pop) rrp <= rrp + AW'(1);
            rcnt <= rcnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
        end
    end

    // Line errors are sticky until read; a new event beats the clear
    assign force_err = wr & (idx == REG_LSTAT) & loop;
    assign lset = ({new_ent.brk, new_ent.fe, new_ent.pe, 1'b0} &
        {4{rx_push}}) | {3'h0, ovr} |
        (force_err ? d[4:1] : 4'h0);
    assign thre = (tcnt == '0);
    assign temt = thre & (tx_st == TX_IDLE);
    assign cts_chg = cts ^ cts_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lerr <= 4'h0;
            cts_q <= 1'b0;
            dcd_q <= 1'b0;
            dcts <= 1'b0;
            ddcd <= 1'b0;
            thre_q <= 1'b1;
            thri <= 1'b0;
        end else begin
            lerr <= (rd_lstat ? 4'h0 : lerr) | lset;
            cts_q <= cts;
            dcd_q <= dcd;
            dcts <= (rd_mstat ? 1'b0 : dcts) | cts_chg;
            ddcd <= (rd_mstat ? 1'b0 : ddcd) | (dcd ^ dcd_q);
            thre_q <= thre;
            thri <= ((rd_iid && iid == IID_TX) || wr_data ? 1'b0 : thri) |
                (thre & ~thre_q);
        end
    end

    // Interrupt identification, highest priority first
    assign lvl = trig == 2'h0 ? TRIG_L0 : trig == 2'h1 ? TRIG_L1 :
        trig == 2'h2 ? TRIG_L2 : TRIG_L3;
    assign rx_full_lvl = rcnt >= (AW+1)'(lvl);
    assign ls_int = ien[IE_LS] & (|lerr);
    assign rx_int = ien[IE_RX] & (fifo_en ? rx_full_lvl : rcnt != '0);
    assign tx_int = ien[IE_TX] & thri;
    // Auto CTS owns the CTS line, so its changes raise nothing
    assign ms_int = ien[IE_MS] & ((dcts & ~auto_on) | ddcd);
    assign iid = ls_int ? IID_LINE : rx_int ? IID_RX :
        tx_int ? IID_TX : ms_int ? IID_MODEM : IID_NONE;

    // Status words, always readable
    assign lstat = {fifo_en & (|lerr[3:1]), temt, thre, lerr,
        rcnt != '0};
    assign mstat = {dcd, 2'b00, cts, ddcd, 2'b00, dcts};
    assign rdata = idx == REG_DATA ?
            (dlab ? divisor[7:0] : rx_head.data) :
        idx == REG_IEN ? (dlab ? divisor[15:8] : {4'h0, ien}) :
        idx == REG_IID ? {fifo_en, fifo_en, 2'b00, iid} :
        idx == REG_LINE ? line :
        idx == REG_MCTL ? {2'b00, mctl} :
        idx == REG_LSTAT ? lstat :
        idx == REG_MSTAT ? mstat : scratch;

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            ser_tx_o <= 1'b1;
            rts_n_o <= 1'b1;
            dtr_n_o <= 1'b1;
            channel_irq_out_o <= 1'b0;
            channel_irq_oe_o <= 1'b0;
        end else begin
            ack_o <= acc;
            // Data lane carries a value only on a read answer
            dat_o <= rd ? {24'h000000, rdata} : 32'h0000_0000;
            ser_tx_o <= loop | (tx_bit & ~line[LC_BRK]);
            rts_n_o <= loop |
                ~(mctl[MC_RTS] & ~(auto_on & rx_full_lvl));
            dtr_n_o <= loop | ~mctl[MC_DTR];
            channel_irq_out_o <= ~iid[0];
            channel_irq_oe_o <= pin[3] | mctl[MC_GATE];
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_start_check;
        rx_st == R_START && tick && rsub == TICK_HALF;
    endsequence

    a_false_start: assert property (
        s_start_check ##0 rx_in |=> rx_st == R_IDLE)
        else $error("Unconfirmed start bit accepted");
    a_start_taken: assert property (
        s_start_check ##0 !rx_in |=> rx_st == R_DATA)
        else $error("Confirmed start bit lost");
    a_ack_single: assert property (
        acc |=> ack_o ##1 !ack_o)
        else $error("Bus answer not a single cycle");
    a_bus_quiet: assert property (
        !ack_o |-> dat_o == 32'h0000_0000)
        else $error("Data driven outside a read answer");
    a_cts_hold: assert property (
        tx_st == TX_IDLE && auto_on && !cts |=> tx_st == TX_IDLE)
        else $error("Transmit started while CTS blocks");
    a_rts_auto: assert property (
        auto_on && !loop && rx_full_lvl |=> rts_n_o)
        else $error("RTS active above threshold");
    a_dtr_follow: assert property (
        !loop |=> dtr_n_o == !$past(mctl[MC_DTR]))
        else $error("DTR does not follow control bit");
    a_irq_hiz: assert property (
        !pin[3] && !mctl[MC_GATE] |=> !channel_irq_oe_o)
        else $error("Interrupt driven while gated");
    a_tx_idle: assert property (
        tx_st == TX_IDLE && !line[LC_BRK] |=> ser_tx_o)
        else $error("Idle transmit line not high");
    a_brk_low: assert property (
        line[LC_BRK] && !loop |=> !ser_tx_o)
        else $error("Break not driven low");
    a_msr_clear: assert property (
        rd_mstat && !cts_chg |=> !dcts)
        else $error("CTS delta not cleared by read");
    a_fifo_cap: assert property (
        tcnt <= cap && rcnt <= cap)
        else $error("Queue above capacity");
endmodule

//--- inc/qasc_pkg.sv
// Package for one asynchronous serial channel: map, fields, timing
package qasc_pkg;
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_IEN = 3'h1;
    localparam logic [2:0] REG_IID = 3'h2;
    localparam logic [2:0] REG_LINE = 3'h3;
    localparam logic [2:0] REG_MCTL = 3'h4;
    localparam logic [2:0] REG_LSTAT = 3'h5;
    localparam logic [2:0] REG_MSTAT = 3'h6;
    localparam logic [2:0] REG_SCRATCH = 3'h7;
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_GATE = 3;
    localparam int MC_LOOP = 4;
    localparam int MC_AUTO = 5;
    localparam int LC_STOP = 2;
    localparam int LC_PEN = 3;
    localparam int LC_EVEN = 4;
    localparam int LC_BRK = 6;
    localparam int LC_DLAB = 7;
    localparam int IE_RX = 0;
    localparam int IE_TX = 1;
    localparam int IE_LS = 2;
    localparam int IE_MS = 3;
    localparam logic [3:0] IEN_RST = 4'h0;
    localparam logic [7:0] LINE_RST = 8'h00;
    localparam logic [5:0] MCTL_RST = 6'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [3:0] SYNC_RST = 4'h7;
    localparam logic [5:0] TICK_LAST = 6'h0f;
    localparam logic [5:0] TICK_HALF = 6'h07;
    localparam logic [5:0] TICK_ONE = 6'h10;
    localparam logic [5:0] TICK_1P5 = 6'h18;
    localparam logic [5:0] TICK_TWO = 6'h20;
    localparam logic [3:0] IID_NONE = 4'h1;
    localparam logic [3:0] IID_LINE = 4'h6;
    localparam logic [3:0] IID_RX = 4'h4;
    localparam logic [3:0] IID_TX = 4'h2;
    localparam logic [3:0] IID_MODEM = 4'h0;
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0e;
    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
        logic [7:0] data;
    } qasc_rx_entry_type;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
        TX_STOP} qasc_tx_state_type;
    typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP,
        R_MARK} qasc_rx_state_type;
endpackage

//--- verif/qasc_serial_peer.sv
// Serial peer model: frames bytes into the channel, decodes its output
`timescale 1ns/1ps
module qasc_serial_peer (
    input wire logic clk_i,
    input wire logic tx_line_i,
    output logic rx_line_o,
    output logic cts_n_o,
    output logic dcd_n_o
);
    int bit_clks = 16;
    int got_count = 0;
    logic [7:0] got_byte = 8'h00;
    logic got_stop = 1'b0;
    logic [7:0] sh;

    // Idle lines: receive pulled high, modem lines inactive
    initial begin
        rx_line_o = 1'b1;
        cts_n_o = 1'b1;
        dcd_n_o = 1'b1;
    end

    // Start, eight bits LSB first, stop; each bit held a full bit time
    task automatic send_byte(input logic [7:0] d);
        logic [9:0] fr;
        fr = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            rx_line_o <= fr[i];
            repeat (bit_clks - 1) @(posedge clk_i);
        end
    endtask

    // Low pulse far shorter than half a bit
    task automatic glitch(input int n);
        @(posedge clk_i);
        rx_line_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rx_line_o <= 1'b1;
    endtask

    task automatic set_modem(input logic cts_n, input logic dcd_n);
        @(posedge clk_i);
        cts_n_o <= cts_n;
        dcd_n_o <= dcd_n;
    endtask

    // Mid-bit sampler; always reads eight bits, so short frames show parity, stop or idle in the top bits
    always begin
        @(negedge tx_line_i);
        repeat (bit_clks / 2) @(posedge clk_i);
        if (tx_line_i === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (bit_clks) @(posedge clk_i);
                sh[i] = tx_line_i;
            end
            repeat (bit_clks) @(posedge clk_i);
            got_stop = tx_line_i;
            got_byte = sh;
            got_count++;
        end
    end
endmodule

//--- verif/qasc_channel_tb.sv
// Self-checking bench for one serial channel behind Wishbone
`timescale 1ns/1ps
module qasc_channel_tb
    import qasc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [4:0] adr_i = 5'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic irq_mode_sel_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o, ser_tx_o, ser_rx_i, cts_n_i, dcd_n_i;
    logic rts_n_o, dtr_n_o, irq_out, irq_oe;
    int err_count = 0;
    int n_tests = 0;

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    qasc_channel dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ser_rx_i(ser_rx_i),
        .cts_n_i(cts_n_i), .dcd_n_i(dcd_n_i),
        .irq_mode_sel_i(irq_mode_sel_i), .ser_tx_o(ser_tx_o),
        .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o), .channel_irq_out_o(irq_out),
        .channel_irq_oe_o(irq_oe));

    qasc_serial_peer peer (.clk_i(clk_i), .tx_line_i(ser_tx_o),
        .rx_line_o(ser_rx_i), .cts_n_o(cts_n_i), .dcd_n_o(dcd_n_i));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [7:0] e,
        input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask

    // A bounded wait that ran out ends the run
    task automatic limit(input int n, input int lim);
        if (n >= lim) begin
            err_count++;
            wrap_up();
        end
    endtask

    // Classic cycle: hold until ack is sampled, then release
    task automatic bus(input logic w, input logic [2:0] a,
        input logic [7:0] d, input logic [3:0] s, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {a, 2'b00};
        sel_i <= s;
        dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        limit(n, 20);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, 4'h1, q);
    endtask

    task automatic rd(input string s, input logic [2:0] a,
        input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, 4'h1, q);
        chk(s, e, q);
    endtask

    // Write a character, wait for the peer to decode it
    task automatic tx_chk(input logic [7:0] d, input logic [7:0] e);
        int n;
        int c;
        n = 0;
        c = peer.got_count;
        wr(REG_DATA, d);
        while (peer.got_count == c && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        limit(n, 1000);
        chk("tx byte", e, peer.got_byte);
        chk("tx stop", 8'h01, peer.got_stop);
    endtask

    task automatic t_reset;
        logic [7:0] q;
        chk("ser_tx", 8'h01, ser_tx_o);
        chk("dtr_n", 8'h01, dtr_n_o);
        chk("irq_oe", 8'h00, irq_oe);
        rd("lstat", REG_LSTAT, 8'h60);
        rd("line", REG_LINE, LINE_RST);
        wr(REG_SCRATCH, 8'ha5);
        rd("scratch", REG_SCRATCH, 8'ha5);
        bus(1'b1, REG_SCRATCH, 8'h5a, 4'he, q);
        rd("scratch", REG_SCRATCH, 8'ha5);
    endtask

    task automatic t_modem;
        wr(REG_IEN, 8'h08);
        wr(REG_MCTL, 8'h09);
        repeat (2) @(posedge clk_i);
        chk("dtr_n", 8'h00, dtr_n_o);
        chk("irq_oe", 8'h01, irq_oe);
        peer.set_modem(1'b0, 1'b0);
        repeat (8) @(posedge clk_i);
        chk("irq", 8'h01, irq_out);
        rd("iid", REG_IID, {4'h0, IID_MODEM});
        rd("mstat", REG_MSTAT, 8'h99);
        rd("mstat", REG_MSTAT, 8'h90);
        repeat (2) @(posedge clk_i);
        chk("irq", 8'h00, irq_out);
        wr(REG_MCTL, 8'h00);
        repeat (2) @(posedge clk_i);
        chk("dtr_n", 8'h01, dtr_n_o);
        chk("irq_oe", 8'h00, irq_oe);
        irq_mode_sel_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("irq_oe", 8'h01, irq_oe);
        irq_mode_sel_i <= 1'b0;
        wr(REG_IEN, 8'h00);
        peer.set_modem(1'b1, 1'b1);
        repeat (8) @(posedge clk_i);
        rd("mstat", REG_MSTAT, 8'h09);
    endtask

    // Framing table: line setting, byte written, byte the peer sees
    task automatic t_tx;
        logic [7:0] tl[5] = '{8'h03, 8'h00, 8'h1a, 8'h0a, 8'h0d};
        logic [7:0] td[5] = '{8'ha5, 8'h15, 8'h43, 8'h43, 8'h2a};
        logic [7:0] te[5] = '{8'ha5, 8'hf5, 8'hc3, 8'h43, 8'haa};
        for (int i = 0; i < 5; i++) begin
            wr(REG_LINE, tl[i]);
            tx_chk(td[i], te[i]);
        end
    endtask

    task automatic t_rx;
        wr(REG_LINE, 8'h03);
        peer.glitch(3);
        repeat (300) @(posedge clk_i);
        rd("lstat", REG_LSTAT, 8'h60);
        peer.send_byte(8'h3c);
        repeat (20) @(posedge clk_i);
        rd("lstat", REG_LSTAT, 8'h61);
        rd("rx data", REG_DATA, 8'h3c);
        rd("lstat", REG_LSTAT, 8'h60);
    endtask

    // FIFO mode: auto RTS level, auto CTS hold, loopback, forced errors
    task automatic t_fifo;
        int c;
        wr(REG_IID, 8'h41);
        wr(REG_MCTL, 8'h22);
        repeat (2) @(posedge clk_i);
        chk("rts_n", 8'h00, rts_n_o);
        peer.send_byte(8'h11);
        peer.send_byte(8'h22);
        peer.send_byte(8'h33);
        repeat (4) @(posedge clk_i);
        chk("rts_n", 8'h00, rts_n_o);
        peer.send_byte(8'h44);
        repeat (4) @(posedge clk_i);
        chk("rts_n", 8'h01, rts_n_o);
        rd("lstat", REG_LSTAT, 8'h61);
        rd("rx first", REG_DATA, 8'h11);
        repeat (2) @(posedge clk_i);
        chk("rts_n", 8'h00, rts_n_o);
        // CTS pin is still inactive here, so the byte must wait
        c = peer.got_count;
        wr(REG_DATA, 8'h77);
        repeat (300) @(posedge clk_i);
        chk("tx held", 8'(c), 8'(peer.got_count));
        peer.set_modem(1'b0, 1'b1);
        repeat (300) @(posedge clk_i);
        chk("tx sent", 8'(c + 1), 8'(peer.got_count));
        chk("tx byte", 8'h77, peer.got_byte);
        wr(REG_IID, 8'h43);
        wr(REG_MCTL, 8'h10);
        wr(REG_DATA, 8'h5a);
        repeat (100) @(posedge clk_i);
        chk("ser_tx", 8'h01, ser_tx_o);
        repeat (100) @(posedge clk_i);
        rd("loop data", REG_DATA, 8'h5a);
        wr(REG_IEN, 8'h04);
        wr(REG_LSTAT, 8'h1e);
        rd("iid", REG_IID, 8'hc6);
        rd("lstat", REG_LSTAT, 8'hfe);
        rd("lstat", REG_LSTAT, 8'h60);
        rd("iid", REG_IID, 8'hc1);
        wr(REG_MCTL, 8'h00);
        wr(REG_IEN, 8'h00);
        wr(REG_IID, 8'h00);
    endtask

    // Divisor two doubles the bit time; then break holds the line low
    task automatic t_div_brk;
        wr(REG_LINE, 8'h83);
        wr(REG_DATA, 8'h02);
        wr(REG_IEN, 8'h00);
        wr(REG_LINE, 8'h03);
        peer.bit_clks = 32;
        tx_chk(8'h5c, 8'h5c);
        wr(REG_LINE, 8'h43);
        repeat (40) @(posedge clk_i);
        chk("ser_tx", 8'h00, ser_tx_o);
        wr(REG_LINE, 8'h03);
        repeat (4) @(posedge clk_i);
        chk("ser_tx", 8'h01, ser_tx_o);
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        err_count++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_modem();
        t_tx();
        t_rx();
        t_fifo();
        t_div_brk();
        wrap_up();
    end
endmodule
